// ### psehio_pkg.sv
// Purpose: constants and state types for the host-side signalling block
// Assumes: 40 MHz block clock, one message length for both host links
// Notes:   bus and serial timing counts derive from the block clock rate

package psehio_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 40_000_000;
   localparam int BUS_MAX_HZ   = 400_000;           // Host bus clock limit
   localparam int BUS_MIN_CYC  = CLK_HZ / BUS_MAX_HZ;
   localparam int SERIAL_BPS   = 19_200;
   localparam logic [11:0] BAUD_CYC = 12'(CLK_HZ / SERIAL_BPS);
   localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / SERIAL_BPS / 2);

   // -----------------------------------------------------------------
   // Message framing and address selection
   // -----------------------------------------------------------------
   localparam int          MSG_LEN   = 15;
   localparam logic [3:0]  LAST_IDX  = 4'he;        // Index of final byte
   localparam logic [2:0]  SERIAL_CODE = 3'h0;      // Level code for serial mode
   localparam logic [6:0]  ADDR_BASE = 7'h20;       // Slave address for level 0
   localparam logic [1:0]  SETTLE_END = 2'h3;       // Cycles before level capture

   typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WR, WR_ACK, RD, RD_ACK} psehio_bus_t;

   typedef struct packed {
      logic                         scl_s1, scl_s2, scl_d;
      logic                         sda_s1, sda_s2, sda_d;
      logic                         rx_s1, rx_s2, dis_s1, dis_s2;
      logic [2:0]                   lvl_s1, lvl_s2;
      logic [1:0]                   settle;
      logic                         addr_done, serial_mode;
      logic [6:0]                   slave_addr;
      psehio_bus_t                  st;
      logic [7:0]                   sh;
      logic [3:0]                   bitc;
      logic                         rw, scl_oe, sda_oe;
      logic [MSG_LEN-1:0][7:0]      reply;
      logic [3:0]                   wr_idx, idx, tidx, cmd_cnt;
      logic                         pending;
      logic                         rbusy;
      logic [11:0]                  rcnt;
      logic [3:0]                   rbit;
      logic [7:0]                   rsh;
      logic                         tbusy;
      logic [11:0]                  tcnt;
      logic [3:0]                   tbit;
      logic [9:0]                   tsh;
      logic                         tx, lo;
      logic [7:0]                   cmd_data;
      logic                         cmd_valid, cmd_last;
      logic                         pend_n, notify_n, sel_n, strb_n, oe_n;
      logic                         fan, ports_off, valid_n;
   } psehio_state_t;

   localparam psehio_state_t ST_RESET = '{scl_s1:1'b1, scl_s2:1'b1, scl_d:1'b1,
      sda_s1:1'b1, sda_s2:1'b1, sda_d:1'b1, rx_s1:1'b1, rx_s2:1'b1, dis_s1:1'b1,
      dis_s2:1'b1, tx:1'b1, pend_n:1'b1, notify_n:1'b1, sel_n:1'b1, strb_n:1'b1,
      oe_n:1'b1, valid_n:1'b1, st:IDLE, default:'0};

endpackage : psehio_pkg

// ### psehio_top.sv
// Purpose: host bus slave, serial port and status pins of the controller
// Assumes: user logic consumes command bytes and supplies reply bytes
// Notes:   bus pins are split into input, output and output enable
`timescale 1ns/100ps

module psehio_top #(
   parameter int EVT_W  = 8,
   parameter int COND_W = 8
) (
   input  wire logic              CLK,                  // 40 MHz clock
   input  wire logic              RST_B,                // Sync reset, low
   input  wire logic              CE,                   // Clock enable
   input  wire logic              HOST_BUS_CLOCK_I,     // Bus clock level
   output logic                   HOST_BUS_CLOCK_O,     // Bus clock drive, always 0
   output logic                   HOST_BUS_CLOCK_OE,    // Hold clock low
   input  wire logic              HOST_BUS_DATA_I,      // Bus data level
   output logic                   HOST_BUS_DATA_O,      // Bus data drive, always 0
   output logic                   HOST_BUS_DATA_OE,     // Pull data low
   input  wire logic [2:0]        BUS_ADDR_SELECT_LEVEL,// Digitised select level
   input  wire logic              HOST_SERIAL_RX,       // Serial in
   output logic                   HOST_SERIAL_TX,       // Serial out
   output logic [7:0]             CMD_DATA,             // Command byte
   output logic                   CMD_VALID,            // Command byte strobe
   output logic                   CMD_LAST,             // Last byte of message
   input  wire logic              CMD_READY,            // Sink can take a byte
   input  wire logic [7:0]        REPLY_DATA,           // Reply byte
   input  wire logic              REPLY_WR,             // Reply byte strobe
   output logic                   REPLY_PENDING_N,      // Reply held, low
   input  wire logic [EVT_W-1:0]  EVENT_ACTIVE,         // Events in progress
   input  wire logic [EVT_W-1:0]  EVENT_MASK,           // Events that notify
   output logic                   EVENT_NOTIFY_N,       // Event notify, low
   input  wire logic              LED_SEL,              // LED select request
   input  wire logic              LED_STROBE,           // LED latch request
   input  wire logic              LED_EN,               // LED enable request
   output logic                   LED_SHIFT_SELECT_N,   // LED select, low
   output logic                   LED_SHIFT_STROBE_N,   // LED latch, low
   output logic                   LED_DRIVE_ENABLE_N,   // LED enable, low
   input  wire logic              FAN_ON,               // Fan request
   output logic                   FAN_CONTROL,          // Fan driver, high
   input  wire logic              ALL_PORT_SHUTDOWN_N,  // Shutdown pin, low
   output logic                   PORTS_OFF,            // Power off all ports
   input  wire logic [COND_W-1:0] SYS_COND,             // Conditions, 1 = good
   input  wire logic [COND_W-1:0] SYS_MASK,             // Conditions that count
   output logic                   SYSTEM_VALID_N        // System valid, low
);

   psehio_pkg::psehio_state_t r;
   psehio_pkg::psehio_state_t n;
   logic       scl_rise, scl_fall, bus_start, bus_stop;
   logic       emit;
   logic [7:0] emit_d;

   // ----------------------------------------------------------------
   // Edge detection on synchronised bus lines
   // ----------------------------------------------------------------
   // sampled well above bus rate
   assign scl_rise  = r.scl_s2 & ~r.scl_d;
   assign scl_fall  = ~r.scl_s2 & r.scl_d;
   assign bus_start = r.scl_s2 & r.scl_d & ~r.sda_s2 & r.sda_d;
   assign bus_stop  = r.scl_s2 & r.scl_d & r.sda_s2 & ~r.sda_d;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      n         = r;
      emit      = 1'b0;
      emit_d    = r.sh;
      n.cmd_valid = 1'b0;
      n.cmd_last  = 1'b0;
      // Two-flop synchronisers
      n.scl_s1 = HOST_BUS_CLOCK_I;
      n.scl_s2 = r.scl_s1;
      n.scl_d  = r.scl_s2;
      n.sda_s1 = HOST_BUS_DATA_I;
      n.sda_s2 = r.sda_s1;
      n.sda_d  = r.sda_s2;
      n.rx_s1  = HOST_SERIAL_RX;
      n.rx_s2  = r.rx_s1;
      n.dis_s1 = ALL_PORT_SHUTDOWN_N;
      n.dis_s2 = r.dis_s1;
      n.lvl_s1 = BUS_ADDR_SELECT_LEVEL;
      n.lvl_s2 = r.lvl_s1;

      if (!r.addr_done)
      begin
         n.settle = r.settle + 2'h1;
         if (r.settle == psehio_pkg::SETTLE_END)
         begin
            n.addr_done   = 1'b1;
            n.serial_mode = (r.lvl_s2 == psehio_pkg::SERIAL_CODE);
            n.slave_addr  = psehio_pkg::ADDR_BASE + {4'h0, r.lvl_s2};
         end
      end

      // Reply buffer fill by user logic
      if (REPLY_WR && !r.pending)
      begin
         n.reply[r.wr_idx] = REPLY_DATA;
         if (r.wr_idx == psehio_pkg::LAST_IDX)
         begin
            n.pending = 1'b1;
            n.wr_idx  = 4'h0;
         end
         else
            n.wr_idx = r.wr_idx + 4'h1;
      end

      // Bus slave sequencer
      if (r.serial_mode || !r.addr_done)
      begin
         n.st     = psehio_pkg::IDLE;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end
      else if (bus_start)
      begin
         n.st      = psehio_pkg::ADDR;
         n.bitc    = 4'h0;
         n.sda_oe  = 1'b0;
         n.cmd_cnt = 4'h0;
      end
      else if (bus_stop)
      begin
         n.st     = psehio_pkg::IDLE;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end
      else
      begin
         unique case (r.st)
            psehio_pkg::IDLE: ;
            psehio_pkg::ADDR:
               if (scl_rise)
               begin
                  n.sh   = {r.sh[6:0], r.sda_s2};
                  n.bitc = r.bitc + 4'h1;
               end
               else if (scl_fall && r.bitc == 4'h8)
               begin
                  if (r.sh[7:1] == r.slave_addr)
                  begin
                     n.sda_oe = 1'b1;
                     n.rw     = r.sh[0];
                     n.st     = psehio_pkg::ADDR_ACK;
                  end
                  else
                     n.st = psehio_pkg::IDLE;
               end
            psehio_pkg::ADDR_ACK:
               if (scl_fall)
               begin
                  n.bitc = 4'h0;
                  if (r.rw)
                  begin
                     n.sh     = r.reply[r.idx];
                     n.sda_oe = ~r.reply[r.idx][7];
                     n.st     = psehio_pkg::RD;
                  end
                  else
                  begin
                     n.sda_oe = 1'b0;
                     n.st     = psehio_pkg::WR;
                  end
               end
            psehio_pkg::WR:
               if (scl_rise)
               begin
                  n.sh   = {r.sh[6:0], r.sda_s2};
                  n.bitc = r.bitc + 4'h1;
               end
               else if (scl_fall && r.bitc == 4'h8)
               begin
                  n.sda_oe = 1'b1;
                  n.st     = psehio_pkg::WR_ACK;
                  if (CMD_READY)
                     emit = 1'b1;
                  else
                     n.scl_oe = 1'b1;
               end
            psehio_pkg::WR_ACK:
               if (r.scl_oe)
               begin
                  if (CMD_READY)
                  begin
                     n.scl_oe = 1'b0;
                     emit     = 1'b1;
                  end
               end
               else if (scl_fall)
               begin
                  n.sda_oe = 1'b0;
                  n.bitc   = 4'h0;
                  n.st     = psehio_pkg::WR;
               end
            psehio_pkg::RD:
               if (scl_fall)
               begin
                  if (r.bitc == 4'h7)
                  begin
                     n.sda_oe = 1'b0;
                     n.st     = psehio_pkg::RD_ACK;
                  end
                  else
                  begin
                     n.sh     = {r.sh[6:0], 1'b0};
                     n.sda_oe = ~r.sh[6];
                     n.bitc   = r.bitc + 4'h1;
                  end
               end
            psehio_pkg::RD_ACK:
               if (scl_rise)
               begin
                  if (r.pending && r.idx == psehio_pkg::LAST_IDX)
                  begin
                     n.idx     = 4'h0;
                     n.pending = 1'b0;
                  end
                  else if (r.pending)
                     n.idx = r.idx + 4'h1;
                  n.st = r.sda_s2 ? psehio_pkg::IDLE : psehio_pkg::ADDR_ACK;
               end
         endcase
      end

      if (!r.serial_mode)
         n.rbusy = 1'b0;
      else if (!r.rbusy)
      begin
         if (!r.rx_s2)
         begin
            n.rbusy = 1'b1;
            n.rcnt  = psehio_pkg::HALF_CYC;
            n.rbit  = 4'h0;
         end
      end
      else if (r.rcnt != 12'h000)
         n.rcnt = r.rcnt - 12'h001;
      else
      begin
         n.rcnt = psehio_pkg::BAUD_CYC - 12'h001;
         n.rbit = r.rbit + 4'h1;
         if (r.rbit == 4'h0)
            n.rbusy = ~r.rx_s2;
         else if (r.rbit == 4'h9)
         begin
            n.rbusy = 1'b0;
            emit    = r.rx_s2;
            emit_d  = r.rsh;
         end
         else
            n.rsh = {r.rx_s2, r.rsh[7:1]};
      end

      if (!r.tbusy)
      begin
         n.tx = 1'b1;
         if (r.serial_mode && r.pending)
         begin
            n.tbusy = 1'b1;
            n.tsh   = {1'b1, r.reply[r.tidx], 1'b0};
            n.tbit  = 4'h0;
            n.tcnt  = psehio_pkg::BAUD_CYC - 12'h001;
            n.tx    = 1'b0;
         end
      end
      else if (r.tcnt != 12'h000)
         n.tcnt = r.tcnt - 12'h001;
      else
      begin
         n.tcnt = psehio_pkg::BAUD_CYC - 12'h001;
         if (r.tbit == 4'h9)
         begin
            n.tbusy = 1'b0;
            n.tx    = 1'b1;
            if (r.tidx == psehio_pkg::LAST_IDX)
            begin
               n.tidx    = 4'h0;
               n.pending = 1'b0;
            end
            else
               n.tidx = r.tidx + 4'h1;
         end
         else
         begin
            n.tsh  = {1'b1, r.tsh[9:1]};
            n.tbit = r.tbit + 4'h1;
            n.tx   = r.tsh[1];
         end
      end

      if (emit)
      begin
         n.cmd_data  = emit_d;
         n.cmd_valid = 1'b1;
         n.cmd_last  = (r.cmd_cnt == psehio_pkg::LAST_IDX);
         n.cmd_cnt   = n.cmd_last ? 4'h0 : r.cmd_cnt + 4'h1;
      end

      // Status pins
      n.pend_n   = ~n.pending;
      n.notify_n = ~|(EVENT_ACTIVE & EVENT_MASK);
      n.sel_n    = ~LED_SEL;
      n.strb_n   = ~LED_STROBE;
      n.oe_n     = ~LED_EN;
      n.fan      = FAN_ON;
      n.ports_off = ~r.dis_s2;
      n.valid_n  = ~&(SYS_COND | ~SYS_MASK);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         r <= psehio_pkg::ST_RESET;
      else if (CE)
         r <= n;
   end

   // Output pins
   assign HOST_BUS_CLOCK_O   = r.lo;
   assign HOST_BUS_CLOCK_OE  = r.scl_oe;
   assign HOST_BUS_DATA_O    = r.lo;
   assign HOST_BUS_DATA_OE   = r.sda_oe;
   assign HOST_SERIAL_TX     = r.tx;
   assign CMD_DATA           = r.cmd_data;
   assign CMD_VALID          = r.cmd_valid;
   assign CMD_LAST           = r.cmd_last;
   assign REPLY_PENDING_N    = r.pend_n;
   assign EVENT_NOTIFY_N     = r.notify_n;
   assign LED_SHIFT_SELECT_N = r.sel_n;
   assign LED_SHIFT_STROBE_N = r.strb_n;
   assign LED_DRIVE_ENABLE_N = r.oe_n;
   assign FAN_CONTROL        = r.fan;
   assign PORTS_OFF          = r.ports_off;
   assign SYSTEM_VALID_N     = r.valid_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B || !CE);

   sequence s_tx_load;
      !r.tbusy && r.serial_mode && r.pending;
   endsequence

   chk_pending_low: assert property ((REPLY_WR && !r.pending && r.wr_idx == 4'he) |=>
      !REPLY_PENDING_N) else $error("reply pending not low with reply held");
   chk_pending_release: assert property ($fell(r.pending) |->
      ($past(r.idx) == 4'he || $past(r.tidx) == 4'he)) else $error("early release");
   chk_notify_level: assert property
      (|(EVENT_ACTIVE & EVENT_MASK) |=> !EVENT_NOTIFY_N) else $error("notify missed");
   chk_led_strobes: assert property ((LED_SEL && !LED_EN) |=>
      (!LED_SHIFT_SELECT_N && LED_DRIVE_ENABLE_N)) else $error("LED polarity wrong");
   chk_fan_drive: assert property (FAN_ON |=> FAN_CONTROL)
      else $error("fan not driven");
   chk_port_shutdown: assert property (!r.dis_s2 |=> PORTS_OFF)
      else $error("ports not shut down");
   chk_valid_mask: assert property ((&(SYS_COND | ~SYS_MASK)) |=>
      !SYSTEM_VALID_N) else $error("system valid wrong");
   chk_serial_quiet: assert property (r.serial_mode |-> ##1 !HOST_BUS_DATA_OE)
      else $error("bus driven in serial mode");
   chk_stretch_end: assert property ((r.scl_oe && CMD_READY) |=>
      (!HOST_BUS_CLOCK_OE && CMD_VALID)) else $error("stretch not ended");
   chk_tx_start: assert property (s_tx_load |=> (r.tbusy && !HOST_SERIAL_TX))
      else $error("serial start bit missing");
   chk_frame_last: assert property (CMD_LAST |-> CMD_VALID && $past(r.cmd_cnt) == 4'he)
      else $error("message framing wrong");

endmodule : psehio_top

// ### psehio_host_model.sv
// Purpose: host bus master model on the open-drain clock and data lines
// Assumes: lines resolved in the bench, high when nobody pulls
// Notes:   quarter bit of 25 cycles keeps the clock at 400 KHz
`timescale 1ns/100ps

module psehio_host_model (
   input  wire logic clk,    // Block clock, paces the model
   input  wire logic scl,    // Clock line level
   input  wire logic sda,    // Data line level
   output logic      scl_oe, // Pull clock low
   output logic      sda_oe, // Pull data low
   output logic      hang    // Clock held too long
);
   // Lines released at start
   initial
   begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      hang   = 1'b0;
   end

   // quarter of a 400 KHz bit
   task automatic q();
      repeat (psehio_pkg::BUS_MIN_CYC / 4) @(posedge clk);
      #1;
   endtask : q

   task automatic rise();
      int n;
      scl_oe = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      hang = hang | (n >= 4000);
      q();
   endtask : rise

   // One bit out, line level sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_oe = ~b;
      q();
      rise();
      r = sda;
      q();
      scl_oe = 1'b1;
      q();
   endtask : bit_io

   task automatic xfer(input logic [7:0] wd, input logic ack_in,
                       output logic [7:0] rd, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(wd[i], rd[i]);
      bit_io(ack_in, ack);
   endtask : xfer

   // Start: data falls while clock high
   task automatic start();
      sda_oe = 1'b0;
      q();
      rise();
      sda_oe = 1'b1;
      q();
      scl_oe = 1'b1;
      q();
   endtask : start

   // Stop: data rises while clock high
   task automatic stop();
      sda_oe = 1'b1;
      q();
      rise();
      sda_oe = 1'b0;
      q();
   endtask : stop
endmodule : psehio_host_model

// ### pse_host_io_signalling_test.sv
// Purpose: self-checking bench for the host-side signalling block
// Assumes: select level 1 gives slave address 0x21, level 0 serial mode
// Notes:   host bus paced by the master model at 400 KHz
`timescale 1ns/100ps

module pse_host_io_signalling_test;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       CLK, RST_B, SCL, SDA, CMD_READY, REPLY_WR, LED_SEL, LED_STROBE, LED_EN;
   logic       FAN_ON, ALL_PORT_SHUTDOWN_N, SCL_OE, SDA_OE, TX, CMD_VALID, CMD_LAST;
   logic       PEND_N, NOTIFY_N, SEL_N, STRB_N, OE_N, FAN, PORTS_OFF, VALID_N;
   logic       H_SCL_OE, H_SDA_OE, HANG, RX, SCL_O, SDA_O;
   logic [2:0] LVL;
   logic [7:0] REPLY_DATA, EVENT_ACTIVE, EVENT_MASK, SYS_COND, SYS_MASK, CMD_DATA;
   logic [7:0] cmd_q[$];
   logic       last_q[$];
   int         failures, tests_run, cycles, stretch;

   // Open-drain lines, pulled up when released
   assign SCL = ~(H_SCL_OE | SCL_OE);
   assign SDA = ~(H_SDA_OE | SDA_OE);

   psehio_top dut (
      .CLK(CLK), .RST_B(RST_B), .CE(1'b1), .HOST_BUS_CLOCK_I(SCL),
      .HOST_BUS_CLOCK_O(SCL_O), .HOST_BUS_CLOCK_OE(SCL_OE), .HOST_BUS_DATA_I(SDA),
      .HOST_BUS_DATA_O(SDA_O), .HOST_BUS_DATA_OE(SDA_OE), .BUS_ADDR_SELECT_LEVEL(LVL),
      .HOST_SERIAL_RX(RX), .HOST_SERIAL_TX(TX), .CMD_DATA(CMD_DATA),
      .CMD_VALID(CMD_VALID), .CMD_LAST(CMD_LAST), .CMD_READY(CMD_READY),
      .REPLY_DATA(REPLY_DATA), .REPLY_WR(REPLY_WR), .REPLY_PENDING_N(PEND_N),
      .EVENT_ACTIVE(EVENT_ACTIVE), .EVENT_MASK(EVENT_MASK), .EVENT_NOTIFY_N(NOTIFY_N),
      .LED_SEL(LED_SEL), .LED_STROBE(LED_STROBE), .LED_EN(LED_EN),
      .LED_SHIFT_SELECT_N(SEL_N), .LED_SHIFT_STROBE_N(STRB_N),
      .LED_DRIVE_ENABLE_N(OE_N), .FAN_ON(FAN_ON), .FAN_CONTROL(FAN),
      .ALL_PORT_SHUTDOWN_N(ALL_PORT_SHUTDOWN_N), .PORTS_OFF(PORTS_OFF),
      .SYS_COND(SYS_COND), .SYS_MASK(SYS_MASK), .SYSTEM_VALID_N(VALID_N)
   );

   psehio_host_model host (
      .clk(CLK), .scl(SCL), .sda(SDA), .scl_oe(H_SCL_OE), .sda_oe(H_SDA_OE), .hang(HANG)
   );

   // ---------------------------------------------------------------
   // Clock, monitors and run limit
   // ---------------------------------------------------------------
   always #12.5 CLK = ~CLK;

   // Command bytes, stretch cycles, hang cut-off
   always @(posedge CLK)
   begin
      cycles++;
      if (CMD_VALID === 1'b1)
      begin
         cmd_q.push_back(CMD_DATA);
         last_q.push_back(CMD_LAST);
      end
      if (SCL_OE === 1'b1)
         stretch++;
      if (cycles == 80000)
      begin
         failures++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : tick

   task automatic do_reset(input logic [2:0] lvl);
      RST_B = 1'b0;
      LVL   = lvl;
      tick(5);
      RST_B = 1'b1;
      tick(8);
   endtask : do_reset

   task automatic finish_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // fill the reply, poll for pending
   task automatic load_reply();
      int n;
      for (int i = 0; i < 15; i++)
      begin
         REPLY_DATA = 8'h35 + 8'(i);
         REPLY_WR   = 1'b1;
         chk(PEND_N, 1'b1);
         tick(1);
      end
      REPLY_WR = 1'b0;
      for (n = 0; n < 4 && PEND_N !== 1'b0; n++)
         tick(1);
      chk(PEND_N, 1'b0);
   endtask : load_reply

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // status pins
   task automatic test_pins();
      for (int i = 0; i < 4; i++)
      begin
         EVENT_ACTIVE = 8'h11 << i;
         EVENT_MASK   = 8'h05;
         {LED_SEL, LED_STROBE, LED_EN, FAN_ON} = {i[0], i[1], ~i[0], i[1]};
         SYS_COND = 8'hf0 >> i;
         SYS_MASK = 8'h30;
         tick(1);
         chk({NOTIFY_N, SEL_N, STRB_N, OE_N, FAN, VALID_N}, {~|(EVENT_ACTIVE & EVENT_MASK),
             ~i[0], ~i[1], i[0], i[1], (SYS_COND & SYS_MASK) != SYS_MASK});
      end
      ALL_PORT_SHUTDOWN_N = 1'b0;
      tick(2);
      chk(PORTS_OFF, 1'b0);
      tick(1);
      chk(PORTS_OFF, 1'b1);
      ALL_PORT_SHUTDOWN_N = 1'b1;
      tick(4);
      $display("test pins done");
   endtask : test_pins

   task automatic test_write();
      logic [7:0] rd;
      logic       ack;
      cmd_q.delete();
      last_q.delete();
      stretch   = 0;
      CMD_READY = 1'b0;
      host.start();
      host.xfer({7'h21, 1'b0}, 1'b1, rd, ack);
      chk(ack, 1'b0);
      fork
         for (int i = 0; i < 15; i++)
            host.xfer(8'h50 + 8'(i), 1'b1, rd, ack);
         begin
            for (int n = 0; n < 2000 && SCL_OE !== 1'b1; n++)
               tick(1);
            tick(40);
            CMD_READY = 1'b1;
         end
      join
      host.stop();
      chk(ack, 1'b0);
      chk(stretch >= 40, 1'b1);
      chk(HANG, 1'b0);
      chk(cmd_q.size(), 15);
      for (int i = 0; i < cmd_q.size(); i++)
         chk({last_q[i], cmd_q[i]}, {i == 14, 8'h50 + 8'(i)});
      $display("test write done");
   endtask : test_write

   task automatic test_nack(input logic [6:0] a);
      logic [7:0] rd;
      logic       ack;
      host.start();
      host.xfer({a, 1'b0}, 1'b1, rd, ack);
      host.stop();
      chk(ack, 1'b1);
      $display("test nack done");
   endtask : test_nack

   // read reply, release after last byte
   task automatic test_read();
      logic [7:0] rd;
      logic       ack;
      load_reply();
      host.start();
      host.xfer({7'h21, 1'b1}, 1'b1, rd, ack);
      chk(ack, 1'b0);
      for (int i = 0; i < 15; i++)
      begin
         host.xfer(8'hff, i == 14, rd, ack);
         chk(rd, 8'h35 + 8'(i));
         if (i == 13)
            chk(PEND_N, 1'b0);
      end
      host.stop();
      chk(PEND_N, 1'b1);
      $display("test read done");
   endtask : test_read

   task automatic test_serial();
      do_reset(3'h0);
      test_nack(7'h21);
      cmd_q.delete();
      last_q.delete();
      load_reply();
      fork
         begin
            for (int n = 0; n < 8 && TX !== 1'b0; n++)
               tick(1);
            tick(1041);
            chk(TX, 1'b0);
            for (int b = 0; b < 3; b++)
            begin
               tick(2083);
               chk(TX, 1'(8'h35 >> b));
            end
         end
         for (int b = 0; b < 10; b++)
         begin
            RX = (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : 1'(8'ha6 >> (b - 1));
            tick(2083);
         end
      join
      chk(cmd_q.size(), 1);
      chk({last_q[0], cmd_q[0]}, {1'b0, 8'ha6});
      $display("test serial done");
   endtask : test_serial

   // Main sequence
   initial
   begin
      CLK = 1'b0;
      {RST_B, CMD_READY, REPLY_WR, LED_SEL, LED_STROBE, LED_EN, FAN_ON} = '0;
      ALL_PORT_SHUTDOWN_N = 1'b1;
      RX = 1'b1;
      {REPLY_DATA, EVENT_ACTIVE, EVENT_MASK, SYS_COND, SYS_MASK} = '0;
      do_reset(3'h1);
      chk({PEND_N, TX, SCL_OE, SDA_OE, CMD_VALID, PORTS_OFF, SCL_O, SDA_O}, 8'hc0);
      test_pins();
      test_write();
      test_nack(7'h22);
      test_read();
      test_serial();
      finish_test();
   end
endmodule : pse_host_io_signalling_test
